// ---- rtl/sli_pkg.sv ----
/*
  Shared constants and types for the asynchronous serial line interface.
  Assumes a single 40 MHz system clock.
*/
package sli_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD_DEF = 9600;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PROTO_LEGACY = 2'h0;
  localparam logic [1:0] PROTO_PEER = 2'h1;
  localparam logic [1:0] PROTO_PEER_EXT = 2'h2;
  localparam logic [1:0] PROTO_RTU = 2'h3;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_LVL = 1'b0;
  localparam logic STOP_LVL = 1'b1;
  localparam int unsigned TMO_MS_DEF = 500;
  localparam int unsigned TMO_TICK_US = 1;
  localparam int unsigned TMO_TICK_CYC = CLK_HZ / 1000000 * TMO_TICK_US;

  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic overrun_err;
    logic framing_err;
  } rx_char_s;
endpackage

// ---- rtl/sli_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module sli_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  // A push into a full FIFO lands when the same cycle pops
  assign push = i_in_valid && (o_in_ready || pop);
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  chk_fifo_no_overfill :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule // sli_fifo

// ---- rtl/sli_baud.sv ----
/*
  Bit-rate divider giving one-cycle enable pulses at sixteen times the rate.
  Assumes the divisor is set while the line is quiet.
*/
`timescale 1ns/100ps
module sli_baud #(
  parameter int DW = 16
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Divisor, in system cycles per oversample tick
  input wire logic [DW-1:0] i_div,
  // Tick
  output logic o_tick
);
  logic [DW-1:0] cnt_q;

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end
    else if (cnt_q >= i_div - 1'b1)
    begin
      cnt_q <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule // sli_baud

// ---- rtl/sli_top.sv ----
/*
  Asynchronous serial line interface: transmitter, receiver with parity,
  overrun and framing checks, receive FIFO and response timeout.
  Assumes inputs synchronous to i_mclk; remote station uses the same rate.
*/
// Operation
// - Frame: start, eight data bits LSB first, optional parity, stop.
// - Odd parity: ones in data plus parity count odd.
// - Even parity: ones in data plus parity count even.
// - No parity: parity bit omitted, receiver skips parity check.
// - Legacy host-link protocol allows only odd or none parity.
// - Receiver checks parity of each character, flags mismatch.
// - New character before old taken overwrites it, flags overrun; here a 4-deep FIFO queues it and drops the oldest only when full.
// - Stop bit sampled; framing error when it is not 1.
// - Target must reply within limit, else timeout aborts transaction.
// - Headers ASCII, payload raw binary; bytes carried unchanged.
// - Detect start falling edge, sample each bit mid-period.
// - Line held at 1 after last bit and while idle.
// - Both ends use the same configured bit rate.
`timescale 1ns/100ps
module sli_top
  import sli_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter int TMO_W = 24
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Configuration
  input wire logic [DIV_W-1:0] i_div,
  input wire logic [1:0] i_parity,
  input wire logic [1:0] i_protocol,
  input wire logic [TMO_W-1:0] i_tmo_limit,
  // Serial line
  input wire logic i_rxd,
  output logic o_txd,
  // Transmit request
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Receive character
  output logic o_rx_valid,
  output sli_pkg::rx_char_s o_rx_char,
  input wire logic i_rx_ready,
  // Sticky errors
  input wire logic i_err_ack,
  output logic o_parity_err,
  output logic o_overrun_err,
  output logic o_framing_err,
  // Response timeout
  input wire logic i_txn_start,
  input wire logic i_txn_reply,
  output logic o_txn_busy,
  output logic o_timeout
);
  import sli_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} bit_e;

  logic tick;
  logic [1:0] par_eff;
  logic par_on;
  logic par_odd;

  sli_baud #(.DW(DIV_W)) u_baud (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_div(i_div),
    .o_tick(tick)
  );

  // Even parity is refused under the legacy protocol
  always_comb
  begin
    if (i_protocol == PROTO_LEGACY && i_parity == PAR_EVEN)
    begin
      par_eff = PAR_NONE;
    end
    else
    begin
      par_eff = i_parity;
    end
  end
  assign par_on = (par_eff == PAR_ODD) || (par_eff == PAR_EVEN);
  assign par_odd = (par_eff == PAR_ODD);

  // Transmitter
  bit_e tx_st_q;
  logic [3:0] tx_os_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic tx_par_q;
  logic tx_par_on_q;

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      tx_st_q <= S_IDLE;
      tx_os_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_par_on_q <= 1'b0;
      o_txd <= LINE_IDLE;
      o_tx_ready <= 1'b0;
    end
    else
    begin
      o_tx_ready <= (tx_st_q == S_IDLE) && !(i_tx_valid && o_tx_ready);
      case (tx_st_q)
        S_IDLE:
        begin
          o_txd <= LINE_IDLE;
          if (i_tx_valid && o_tx_ready)
          begin
            tx_sh_q <= i_tx_data;
            tx_par_q <= (^i_tx_data) ^ par_odd;
            tx_par_on_q <= par_on;
            tx_os_q <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_st_q <= S_START;
            o_txd <= START_LVL;
          end
        end
        S_START, S_DATA, S_PAR, S_STOP:
        begin
          if (tick)
          begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == 4'hf)
            begin
              case (tx_st_q)
                S_START:
                begin
                  tx_st_q <= S_DATA;
                  o_txd <= tx_sh_q[0];
                end
                S_DATA:
                begin
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == 3'h7)
                  begin
                    tx_st_q <= tx_par_on_q ? S_PAR : S_STOP;
                    o_txd <= tx_par_on_q ? tx_par_q : STOP_LVL;
                  end
                  else
                  begin
                    o_txd <= tx_sh_q[tx_bit_q + 3'h1];
                  end
                end
                S_PAR:
                begin
                  tx_st_q <= S_STOP;
                  o_txd <= STOP_LVL;
                end
                default:
                begin
                  tx_st_q <= S_IDLE;
                  o_txd <= LINE_IDLE;
                end
              endcase
            end
          end
        end
        default:
        begin
          tx_st_q <= S_IDLE;
        end
      endcase
    end
  end

  // Receiver
  bit_e rx_st_q;
  logic [3:0] rx_os_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_prev_q;
  logic rx_par_ok_q;
  logic rx_done;
  logic rx_ferr;
  logic mid;
  rx_char_s rx_new;

  assign mid = tick && (rx_os_q == 4'h7);
  assign rx_done = mid && (rx_st_q == S_STOP);
  assign rx_ferr = (i_rxd != STOP_LVL);

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      rx_st_q <= S_IDLE;
      rx_os_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_prev_q <= LINE_IDLE;
      rx_par_ok_q <= 1'b1;
    end
    else
    begin
      rx_prev_q <= i_rxd;
      if (rx_st_q == S_IDLE)
      begin
        rx_os_q <= 4'h0;
        if (rx_prev_q == LINE_IDLE && i_rxd == START_LVL)
        begin
          rx_st_q <= S_START;
        end
      end
      else if (tick)
      begin
        rx_os_q <= rx_os_q + 4'h1;
        if (rx_os_q == 4'h7)
        begin
          case (rx_st_q)
            S_START:
            begin
              rx_st_q <= (i_rxd == START_LVL) ? S_DATA : S_IDLE;
              rx_bit_q <= 3'h0;
            end
            S_DATA:
            begin
              rx_sh_q <= {i_rxd, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7)
              begin
                rx_st_q <= par_on ? S_PAR : S_STOP;
              end
            end
            S_PAR:
            begin
              rx_par_ok_q <= ((^rx_sh_q) ^ i_rxd) == par_odd;
              rx_st_q <= S_STOP;
            end
            default:
            begin
              rx_st_q <= S_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_comb
  begin
    rx_new.data = rx_sh_q;
    rx_new.parity_err = par_on && !rx_par_ok_q;
    rx_new.framing_err = rx_ferr;
    rx_new.overrun_err = 1'b0;
  end

  // Receive FIFO; full FIFO drops oldest to keep newest
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_drop;
  rx_char_s fifo_out;
  logic ovr_pend_q;

  assign fifo_drop = rx_done && !fifo_in_ready && !i_rx_ready;

  sli_fifo #(.WIDTH($bits(rx_char_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_in_valid(rx_done),
    .i_in_data(rx_new),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out),
    .i_out_ready(!o_rx_valid || i_rx_ready || fifo_drop)
  );

  // Output holding register
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_rx_valid <= 1'b0;
      o_rx_char <= '0;
      ovr_pend_q <= 1'b0;
    end
    else
    begin
      if (fifo_drop)
      begin
        ovr_pend_q <= 1'b1;
      end
      if (fifo_out_valid && (!o_rx_valid || i_rx_ready || fifo_drop))
      begin
        o_rx_valid <= 1'b1;
        o_rx_char <= fifo_out;
        o_rx_char.overrun_err <= ovr_pend_q || fifo_drop;
        ovr_pend_q <= 1'b0;
      end
      else if (i_rx_ready)
      begin
        o_rx_valid <= 1'b0;
      end
    end
  end

  // Sticky error flags; a new error beats the acknowledge
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_parity_err <= 1'b0;
      o_overrun_err <= 1'b0;
      o_framing_err <= 1'b0;
    end
    else
    begin
      o_parity_err <= (o_parity_err && !i_err_ack)
        || (rx_done && rx_new.parity_err);
      o_framing_err <= (o_framing_err && !i_err_ack)
        || (rx_done && rx_ferr);
      o_overrun_err <= (o_overrun_err && !i_err_ack) || fifo_drop;
    end
  end

  // Response timeout in microsecond ticks
  logic [TMO_W-1:0] tmo_cnt_q;
  logic [7:0] us_q;
  logic us_tick;

  assign us_tick = (us_q == 8'(TMO_TICK_CYC - 1));

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst || !o_txn_busy || us_tick)
    begin
      us_q <= 8'h00;
    end
    else
    begin
      us_q <= us_q + 8'h01;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_txn_busy <= 1'b0;
      o_timeout <= 1'b0;
      tmo_cnt_q <= '0;
    end
    else
    begin
      o_timeout <= 1'b0;
      if (i_txn_start)
      begin
        o_txn_busy <= 1'b1;
        tmo_cnt_q <= '0;
      end
      else if (o_txn_busy && i_txn_reply)
      begin
        o_txn_busy <= 1'b0;
      end
      else if (o_txn_busy && us_tick)
      begin
        tmo_cnt_q <= tmo_cnt_q + 1'b1;
        if (tmo_cnt_q + 1'b1 >= i_tmo_limit)
        begin
          o_txn_busy <= 1'b0;
          o_timeout <= 1'b1;
        end
      end
    end
  end

  // Checks
  chk_idle_line_high :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (tx_st_q == S_IDLE && $past(tx_st_q) == S_IDLE) |-> o_txd)
    else $error("idle line not high");

  chk_stop_bit_high :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (tx_st_q == S_STOP) |-> o_txd)
    else $error("stop bit not high");

  chk_legacy_no_even :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (i_protocol == PROTO_LEGACY) |-> (par_eff != PAR_EVEN))
    else $error("even parity under legacy protocol");

  chk_tx_parity_sense :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (tx_st_q == S_PAR) |-> ((^tx_sh_q) ^ o_txd) == par_odd)
    else $error("wrong transmit parity");

  chk_no_parity_skip :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (!tx_par_on_q) |-> (tx_st_q != S_PAR))
    else $error("parity bit sent with parity off");

  chk_framing_sticky :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (rx_done && rx_ferr) |=> o_framing_err)
    else $error("framing error not flagged");

  chk_parity_sticky :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      (o_parity_err && !i_err_ack) |=> o_parity_err)
    else $error("parity flag dropped without ack");

  chk_overrun_flag :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      fifo_drop |=> o_overrun_err)
    else $error("overrun not flagged");

  chk_timeout_ends :
    assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_timeout |-> !o_txn_busy && $past(o_txn_busy))
    else $error("timeout without busy transaction");
endmodule // sli_top

// ---- bench/remote_station.sv ----
/*
  Remote serial station: frames characters onto the receive line and
  decodes frames from the transmit line. Assumes BIT cycles per bit.
*/
`timescale 1ns/100ps
module remote_station #(
  parameter int BIT = 32
)
(
  // Clock
  input wire logic i_mclk,
  // Serial line
  input wire logic i_txd,
  output logic o_rxd
);
  initial o_rxd = 1'h1;
  // Send one frame, stop level chosen by caller
  task automatic send(input logic [7:0] d, input logic use_par,
    input logic par, input logic stop);
    logic [10:0] f;
    f = {stop, par, d, 1'h0};
    for (int i = 0; i < 11; i++)
    begin
      if (i != 9 || use_par)
      begin
        @(posedge i_mclk);
        o_rxd <= f[i];
        repeat (BIT - 1) @(posedge i_mclk);
      end
    end
    @(posedge i_mclk);
    o_rxd <= 1'h1;
    repeat (BIT - 1) @(posedge i_mclk);
  endtask
  // Decode one frame, sampled mid-bit
  task automatic get(output logic [10:0] f, output logic ok);
    int n;
    n = 0;
    while (i_txd !== 1'h0 && n < 4000)
    begin
      @(posedge i_mclk);
      n++;
    end
    ok = (n < 4000);
    repeat (BIT / 2) @(posedge i_mclk);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = i_txd;
      repeat (BIT) @(posedge i_mclk);
    end
  endtask
endmodule // remote_station

// ---- bench/async_serial_line_interface_tb.sv ----
/*
  Self-checking bench for the serial line interface top.
  Assumes the remote station model runs at the same bit rate.
*/
`timescale 1ns/100ps
module async_serial_line_interface_tb;
  import sli_pkg::*;
  localparam int DIV = 2;
  logic i_mclk = 1'h0, i_nrst = 1'h0;
  logic [15:0] i_div = 16'h0002;
  logic [1:0] i_parity = PAR_NONE, i_protocol = PROTO_PEER;
  logic [23:0] i_tmo_limit = 24'h00_0003;
  logic i_rxd, o_txd, i_tx_valid = 1'h0, o_tx_ready, o_rx_valid;
  logic [7:0] i_tx_data = 8'h00;
  rx_char_s o_rx_char;
  logic i_rx_ready = 1'h0, i_err_ack = 1'h0, o_parity_err;
  logic o_overrun_err, o_framing_err, o_txn_busy, o_timeout;
  logic i_txn_start = 1'h0, i_txn_reply = 1'h0;
  int failures = 0, n_compared = 0;
  rx_char_s c;
  int at;

  always #12.5 i_mclk = ~i_mclk;

  sli_top sli_top_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_div(i_div),
    .i_parity(i_parity), .i_protocol(i_protocol),
    .i_tmo_limit(i_tmo_limit), .i_rxd(i_rxd), .o_txd(o_txd),
    .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
    .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
    .o_rx_char(o_rx_char), .i_rx_ready(i_rx_ready),
    .i_err_ack(i_err_ack), .o_parity_err(o_parity_err),
    .o_overrun_err(o_overrun_err), .o_framing_err(o_framing_err),
    .i_txn_start(i_txn_start), .i_txn_reply(i_txn_reply),
    .o_txn_busy(o_txn_busy), .o_timeout(o_timeout));

  remote_station #(.BIT(16 * DIV)) remote_station_inst (.i_mclk(i_mclk),
    .i_txd(o_txd), .o_rxd(i_rxd));

  task automatic end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic give_up;
    failures++;
    $display("unexpected at %0t: wait ran out", $time);
    end_of_test();
  endtask

  task automatic send_tx(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_tx_valid <= 1'h1;
    i_tx_data <= d;
    do
    begin
      @(posedge i_mclk);
      n++;
    end while (o_tx_ready !== 1'h1 && n < 1000);
    i_tx_valid <= 1'h0;
    if (n >= 1000)
      give_up();
  endtask

  task automatic read_rx(output rx_char_s r);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_rx_ready <= 1'h1;
    do
    begin
      @(posedge i_mclk);
      n++;
    end while (o_rx_valid !== 1'h1 && n < 2000);
    r = o_rx_char;
    i_rx_ready <= 1'h0;
    if (n >= 2000)
      give_up();
  endtask

  task automatic tx_case(input logic [1:0] pr, input logic [1:0] pa,
    input logic exp9);
    logic [10:0] f;
    logic ok;
    @(posedge i_mclk);
    i_protocol <= pr;
    i_parity <= pa;
    fork
      remote_station_inst.get(f, ok);
      send_tx(8'h41);
    join
    check(ok, 1'h1);
    check(f[8:0], {8'h41, 1'h0});
    check(f[9], exp9);
    check(f[10], 1'h1);
    check(o_tx_ready, 1'h1);
  endtask

  task automatic rx_case(input logic [1:0] pa, input logic [7:0] d,
    input logic flip, input logic stop, input logic [2:0] ef);
    @(posedge i_mclk);
    i_parity <= pa;
    remote_station_inst.send(d, pa != PAR_NONE,
      (pa == PAR_ODD ? ~^d : ^d) ^ flip, stop);
    read_rx(c);
    check(c.data, d);
    check({c.parity_err, c.overrun_err, c.framing_err}, ef);
    check(o_parity_err, ef[2]);
    check(o_framing_err, ef[0]);
    @(posedge i_mclk);
    i_err_ack <= 1'h1;
    @(posedge i_mclk);
    i_err_ack <= 1'h0;
    @(posedge i_mclk);
    check({o_parity_err, o_overrun_err, o_framing_err}, 3'h0);
  endtask

  task automatic tmo_run(input int reply_at);
    @(posedge i_mclk);
    i_txn_start <= 1'h1;
    @(posedge i_mclk);
    i_txn_start <= 1'h0;
    at = 0;
    for (int n = 1; n <= 200; n++)
    begin
      @(posedge i_mclk);
      if (n == 2)
        check(o_txn_busy, 1'h1);
      i_txn_reply <= (n == reply_at);
      if (o_timeout === 1'h1 && at == 0)
        at = n;
    end
    check(o_txn_busy, 1'h0);
  endtask

  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'h1;
    repeat (2) @(posedge i_mclk);
    check(o_txd, 1'h1);
    check({o_rx_valid, o_timeout, o_parity_err}, 3'h0);
    $display("test reset done");
    tx_case(PROTO_PEER, PAR_NONE, 1'h1);
    tx_case(PROTO_PEER, PAR_ODD, 1'h1);
    tx_case(PROTO_PEER, PAR_EVEN, 1'h0);
    tx_case(PROTO_RTU, PAR_EVEN, 1'h0);
    tx_case(PROTO_LEGACY, PAR_ODD, 1'h1);
    tx_case(PROTO_LEGACY, PAR_EVEN, 1'h1);
    $display("test transmit done");
    @(posedge i_mclk);
    i_protocol <= PROTO_PEER;
    rx_case(PAR_NONE, 8'h02, 1'h0, 1'h1, 3'h0);
    rx_case(PAR_ODD, 8'h2B, 1'h0, 1'h1, 3'h0);
    rx_case(PAR_EVEN, 8'h15, 1'h0, 1'h1, 3'h0);
    rx_case(PAR_ODD, 8'h39, 1'h1, 1'h1, 3'h4);
    rx_case(PAR_EVEN, 8'h41, 1'h1, 1'h1, 3'h4);
    rx_case(PAR_NONE, 8'h41, 1'h1, 1'h1, 3'h0);
    rx_case(PAR_NONE, 8'hC3, 1'h0, 1'h0, 3'h1);
    $display("test receive done");
    for (int i = 0; i < 6; i++)
      remote_station_inst.send(8'h10 + 8'(i), 1'h0, 1'h0, 1'h1);
    for (int i = 0; i < 5; i++)
    begin
      read_rx(c);
      check(c.data, 8'h11 + 8'(i));
      check(c.overrun_err, i == 0);
    end
    check(c.data, 8'h15);
    check(o_overrun_err, 1'h1);
    repeat (2) @(posedge i_mclk);
    check(o_rx_valid, 1'h0);
    $display("test overrun done");
    tmo_run(0);
    check(at >= 118 && at <= 124, 1'h1);
    tmo_run(20);
    check(at, 0);
    $display("test timeout done");
    end_of_test();
  end
endmodule // async_serial_line_interface_tb
